//--- core/spc_pkg.sv
// Purpose: shared constants and types for the serial port link configuration block
// Assumes: 16-bit settings words, 50 MHz system clock
// Notes: frame format word has no printed offset; one is chosen next to the baud word
package spc_pkg;
    localparam logic [15:0] ADDR_STATION = 16'h0300;
    localparam logic [15:0] ADDR_BAUD = 16'h0302;
    localparam logic [15:0] ADDR_FORMAT = 16'h0304;
    localparam logic [15:0] RST_STATION = 16'h007f;
    localparam logic [15:0] RST_BAUD = 16'h0033;
    localparam logic [15:0] RST_FORMAT = 16'h0066;
    localparam logic [7:0] STATION_MIN = 8'h01;
    localparam logic [7:0] STATION_MAX = 8'h7f;
    localparam logic [7:0] WILDCARD_ADDR = 8'hff;
    localparam logic [3:0] BAUD_CODE_MAX = 4'h5;
    localparam logic [3:0] FORMAT_CODE_MAX = 4'h8;
    localparam int RS232_LSB = 0;
    localparam int RS485_LSB = 4;
    localparam int CLK_HZ = 50000000;
    localparam int BAUD_4800 = 4800;
    localparam int BAUD_9600 = 9600;
    localparam int BAUD_19200 = 19200;
    localparam int BAUD_38400 = 38400;
    localparam int BAUD_57600 = 57600;
    localparam int BAUD_115200 = 115200;
    localparam int DIV_W = 16;

    typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} spc_parity_t;

    typedef struct packed {
        logic rtu;
        logic eight_bits;
        spc_parity_t parity;
        logic two_stop;
    } spc_frame_t;

    typedef struct packed {
        logic [DIV_W-1:0] divisor;
        spc_frame_t frame;
    } spc_port_cfg_t;
endpackage

//--- core/spc_port_decode.sv
// Purpose: turn one port's baud and format codes into a divisor and framing
// Assumes: codes already range-checked
// Notes: purely combinational, outputs registered by the caller
`timescale 1ns/100ps
`default_nettype none
module spc_port_decode (
    input wire logic [3:0] baud_code, // baud code
    input wire logic [3:0] format_code, // frame format code
    output spc_pkg::spc_port_cfg_t cfg // decoded settings
);
    function automatic logic [spc_pkg::DIV_W-1:0] div_of(input int rate);
        div_of = spc_pkg::DIV_W'((spc_pkg::CLK_HZ + rate / 2) / rate);
    endfunction

    always_comb begin
        unique case (baud_code) // R7
            4'h0: cfg.divisor = div_of(spc_pkg::BAUD_4800);
            4'h1: cfg.divisor = div_of(spc_pkg::BAUD_9600);
            4'h2: cfg.divisor = div_of(spc_pkg::BAUD_19200);
            4'h3: cfg.divisor = div_of(spc_pkg::BAUD_38400);
            4'h4: cfg.divisor = div_of(spc_pkg::BAUD_57600);
            default: cfg.divisor = div_of(spc_pkg::BAUD_115200);
        endcase
        // R9 R10 R11
        cfg.frame.rtu = (format_code >= 4'h6);
        cfg.frame.eight_bits = (format_code >= 4'h3);
        unique case (format_code)
            4'h0, 4'h3, 4'h6: cfg.frame.parity = spc_pkg::PAR_NONE;
            4'h1, 4'h4, 4'h7: cfg.frame.parity = spc_pkg::PAR_EVEN;
            default: cfg.frame.parity = spc_pkg::PAR_ODD;
        endcase
        cfg.frame.two_stop = (cfg.frame.parity == spc_pkg::PAR_NONE);
    end
endmodule // spc_port_decode
`default_nettype wire

//--- core/spc_link_config.sv
// Purpose: station address, baud and frame settings for two serial ports, plus address match
// Assumes: parameter writes arrive as address/data strobes on SYS_CLK
// Notes: the same station address serves both serial ports and the CAN side
// Behaviour
// R1: station address accepts only 0x01 to 0x7F.
// R2: integrator gives each drive a unique address on the network.
// R3: one stored address serves RS-232, RS-485 and CAN.
// R4: frames addressed 0xFF are accepted and answered regardless of station.
// R5: station address never takes the wildcard value 0xFF.
// R6: baud word low digit RS-232, next RS-485, range 0x0000 to 0x0055.
// R7: baud codes 0..5 give 4800 to 115200 bits per second.
// R8: format word low digit RS-232, next RS-485, range 0x0000 to 0x0088.
// R9: format codes 0..2 are ASCII seven data bits, N2/E1/O1.
// R10: format codes 3..5 are ASCII eight data bits, N2/E1/O1.
// R11: format codes 6..8 are RTU eight data bits, N2/E1/O1.
// R12: out of range writes are refused, keeping the previous setting.
`timescale 1ns/100ps
`default_nettype none
module spc_link_config (
    input wire logic SYS_CLK, // system clock
    input wire logic RST, // synchronous reset, high
    input wire logic WR_EN, // write strobe
    input wire logic RD_EN, // read strobe
    input wire logic [15:0] ADDR, // parameter address
    input wire logic [15:0] WR_DATA, // write data
    output logic [15:0] RD_DATA, // read data
    output logic RD_VALID, // read answer pulse
    output logic WR_ACK, // write taken pulse
    output logic WR_REFUSED, // write refused pulse
    input wire logic FRAME_VALID, // incoming frame address valid
    input wire logic [7:0] FRAME_ADDR, // incoming frame address byte
    output logic FRAME_ACCEPT, // frame is for this station
    output logic [7:0] STATION_ADDR, // station address to all ports
    output spc_pkg::spc_port_cfg_t RS232_CFG, // RS-232 settings
    output spc_pkg::spc_port_cfg_t RS485_CFG // RS-485 settings
);
    typedef enum logic [1:0] {SEL_NONE, SEL_STATION, SEL_BAUD, SEL_FORMAT} spc_reg_sel_t;

    logic [15:0] station_address;
    logic [15:0] next_station_address;
    logic [15:0] port_baud_select;
    logic [15:0] next_port_baud_select;
    logic [15:0] port_frame_format;
    logic [15:0] next_port_frame_format;
    logic next_wr_ack;
    logic next_wr_refused;

    spc_reg_sel_t wr_sel;
    logic station_in_range;
    logic baud_in_range;
    logic format_in_range;

    logic [15:0] next_rd_data;
    logic next_rd_valid;

    logic next_frame_accept;

    spc_pkg::spc_port_cfg_t cfg232;
    spc_pkg::spc_port_cfg_t cfg485;
    logic [7:0] next_station_out;
    spc_pkg::spc_port_cfg_t next_rs232_cfg;
    spc_pkg::spc_port_cfg_t next_rs485_cfg;

    // one decoder for writes and reads keeps the two register maps from drifting apart
    function automatic spc_reg_sel_t sel_of(input logic [15:0] addr);
        unique case (addr)
            spc_pkg::ADDR_STATION: sel_of = SEL_STATION;
            spc_pkg::ADDR_BAUD: sel_of = SEL_BAUD;
            spc_pkg::ADDR_FORMAT: sel_of = SEL_FORMAT;
            default: sel_of = SEL_NONE;
        endcase
    endfunction

    function automatic logic pair_ok(input logic [15:0] v, input logic [3:0] lim);
        pair_ok = (v[15:8] == 8'h00) && (v[7:4] <= lim) && (v[3:0] <= lim);
    endfunction

    // 0xff fails the upper bound, so the wildcard can never become the stored address
    function automatic logic station_ok(input logic [15:0] v);
        station_ok = (v[15:8] == 8'h00) && (v[7:0] >= spc_pkg::STATION_MIN)
            && (v[7:0] <= spc_pkg::STATION_MAX);
    endfunction

    always_comb begin
        wr_sel = sel_of(ADDR);
        station_in_range = station_ok(WR_DATA); // R1 R5
        baud_in_range = pair_ok(WR_DATA, spc_pkg::BAUD_CODE_MAX); // R6
        format_in_range = pair_ok(WR_DATA, spc_pkg::FORMAT_CODE_MAX); // R8
    end

    // a refused word leaves every register untouched; only the answer pulse tells the host
    always_comb begin
        next_station_address = station_address;
        next_port_baud_select = port_baud_select;
        next_port_frame_format = port_frame_format;
        next_wr_ack = 1'b0;
        next_wr_refused = 1'b0;
        if (WR_EN) begin
            unique case (wr_sel)
                SEL_STATION: begin
                    if (station_in_range) begin // R1 R5
                        next_station_address = WR_DATA;
                        next_wr_ack = 1'b1;
                    end else begin
                        next_wr_refused = 1'b1; // R12
                    end
                end
                SEL_BAUD: begin
                    if (baud_in_range) begin // R6
                        next_port_baud_select = WR_DATA;
                        next_wr_ack = 1'b1;
                    end else begin
                        next_wr_refused = 1'b1; // R12
                    end
                end
                SEL_FORMAT: begin
                    if (format_in_range) begin // R8
                        next_port_frame_format = WR_DATA;
                        next_wr_ack = 1'b1;
                    end else begin
                        next_wr_refused = 1'b1; // R12
                    end
                end
                SEL_NONE: begin
                    next_wr_refused = 1'b1; // R12
                end
            endcase
        end
    end

    // read data holds between reads so a slow host can still pick it up
    always_comb begin
        next_rd_valid = RD_EN;
        next_rd_data = RD_DATA;
        if (RD_EN) begin
            unique case (sel_of(ADDR))
                SEL_STATION: next_rd_data = station_address;
                SEL_BAUD: next_rd_data = port_baud_select;
                SEL_FORMAT: next_rd_data = port_frame_format;
                SEL_NONE: next_rd_data = 16'h0000;
            endcase
        end
    end

    // the stored register is compared, not the output copy, so a new address applies sooner
    always_comb begin
        next_frame_accept = 1'b0;
        if (FRAME_VALID) begin
            if (FRAME_ADDR == spc_pkg::WILDCARD_ADDR) begin
                next_frame_accept = 1'b1; // R4
            end else if (FRAME_ADDR == station_address[7:0]) begin
                next_frame_accept = 1'b1; // R3
            end
        end
    end

    spc_port_decode u_dec232 (
        .baud_code(port_baud_select[spc_pkg::RS232_LSB +: 4]),
        .format_code(port_frame_format[spc_pkg::RS232_LSB +: 4]),
        .cfg(cfg232)
    );

    spc_port_decode u_dec485 (
        .baud_code(port_baud_select[spc_pkg::RS485_LSB +: 4]),
        .format_code(port_frame_format[spc_pkg::RS485_LSB +: 4]),
        .cfg(cfg485)
    );

    always_comb begin
        next_station_out = station_address[7:0]; // R3
        next_rs232_cfg = cfg232;
        next_rs485_cfg = cfg485;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            station_address <= spc_pkg::RST_STATION;
            port_baud_select <= spc_pkg::RST_BAUD;
            port_frame_format <= spc_pkg::RST_FORMAT;
            WR_ACK <= 1'b0;
            WR_REFUSED <= 1'b0;
        end else begin
            station_address <= next_station_address;
            port_baud_select <= next_port_baud_select;
            port_frame_format <= next_port_frame_format;
            WR_ACK <= next_wr_ack;
            WR_REFUSED <= next_wr_refused;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            RD_DATA <= 16'h0000;
            RD_VALID <= 1'b0;
        end else begin
            RD_DATA <= next_rd_data;
            RD_VALID <= next_rd_valid;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            FRAME_ACCEPT <= 1'b0;
        end else begin
            FRAME_ACCEPT <= next_frame_accept;
        end
    end

    // port copies lag the registers by one cycle: a write shows here two edges after it is taken
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            STATION_ADDR <= 8'h00;
            RS232_CFG <= '0;
            RS485_CFG <= '0;
        end else begin
            STATION_ADDR <= next_station_out;
            RS232_CFG <= next_rs232_cfg;
            RS485_CFG <= next_rs485_cfg;
        end
    end
endmodule // spc_link_config
`default_nettype wire

//--- bench/spc_link_config_sva.sv
// Purpose: port-level checks for the link configuration block
// Assumes: answers one cycle after the taking edge, settings outputs one more
// Notes: wildcard frames never depend on the stored station address
`timescale 1ns/100ps
`default_nettype none
module spc_link_config_sva (
    input wire logic SYS_CLK, // clock
    input wire logic RST, // reset
    input wire logic WR_EN, // write strobe
    input wire logic [15:0] ADDR, // address
    input wire logic [15:0] WR_DATA, // write data
    input wire logic WR_ACK, // write taken
    input wire logic WR_REFUSED, // write refused
    input wire logic FRAME_VALID, // frame strobe
    input wire logic [7:0] FRAME_ADDR, // frame address
    input wire logic FRAME_ACCEPT, // frame accepted
    input wire logic [7:0] STATION_ADDR, // station address
    input wire spc_pkg::spc_port_cfg_t RS232_CFG, // rs-232 settings
    input wire spc_pkg::spc_port_cfg_t RS485_CFG // rs-485 settings
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    a_wr_answer: assert property (WR_EN |=> WR_ACK ^ WR_REFUSED)
        else $error("write answer missing or doubled");
    a_station_range: assert property (WR_EN && ADDR == 16'h0300 && (WR_DATA == 16'h0000
        || WR_DATA > 16'h007f) |=> WR_REFUSED) else $error("bad station write taken");
    a_baud_range: assert property (WR_EN && ADDR == 16'h0302 && (WR_DATA[15:8] != 8'h00
        || WR_DATA[7:4] > 4'h5 || WR_DATA[3:0] > 4'h5) |=> WR_REFUSED) else $error("bad baud taken");
    a_fmt_range: assert property (WR_EN && ADDR == 16'h0304 && (WR_DATA[15:8] != 8'h00
        || WR_DATA[7:4] > 4'h8 || WR_DATA[3:0] > 4'h8) |=> WR_REFUSED) else $error("bad format taken");
    a_wild_accept: assert property (FRAME_VALID && FRAME_ADDR == 8'hff |=> FRAME_ACCEPT)
        else $error("wildcard frame not accepted");
    a_station_share: assert property (WR_EN && ADDR == 16'h0300 && WR_DATA inside {[1:127]}
        |=> WR_ACK ##1 STATION_ADDR == $past(WR_DATA[7:0], 2)) else $error("station not shared");
    a_baud_divisor: assert property (WR_EN && ADDR == 16'h0302 && WR_DATA == 16'h0055
        |=> ##1 RS232_CFG.divisor == 16'h01b2 && RS485_CFG.divisor == 16'h01b2)
        else $error("115200 divisor wrong");
    a_frame_codes: assert property (WR_EN && ADDR == 16'h0304 && WR_DATA == 16'h0027 |=> ##1
        RS232_CFG.frame == 5'h1a && RS485_CFG.frame == 5'h04) else $error("frame decode wrong");
    cover property (WR_EN ##1 WR_REFUSED);
    cover property (FRAME_VALID ##1 FRAME_ACCEPT);
    cover property (FRAME_VALID && FRAME_ADDR == 8'hff ##1 FRAME_ACCEPT);
    cover property (WR_EN && ADDR == 16'h0304 ##1 WR_ACK);
endmodule // spc_link_config_sva
bind spc_link_config spc_link_config_sva i_sva (.*);
`default_nettype wire

//--- bench/spc_host_model.sv
// Purpose: host controller sending frame address bytes
// Assumes: one byte per strobe, driven on the falling edge
// Notes: idle bus shows the inverse byte so nothing stale looks valid
`timescale 1ns/100ps
`default_nettype none
module spc_host_model (
    input wire logic sys_clk, // clock
    output logic frame_valid, // byte strobe
    output logic [7:0] frame_addr // address byte
);
    initial begin
        frame_valid = 1'b0;
        frame_addr = 8'h00;
    end
    // gap of at least one cycle keeps strobes apart; one station per address
    task automatic send(input logic [7:0] a, input int gap);
        repeat (gap) @(negedge sys_clk);
        frame_valid = 1'b1;
        frame_addr = a;
        @(negedge sys_clk);
        frame_valid = 1'b0;
        frame_addr = ~a;
    endtask
endmodule // spc_host_model
`default_nettype wire

//--- bench/spc_link_config_tb_top.sv
// Purpose: self-checking bench for the link configuration block
// Assumes: requests launched on the falling edge, answers sampled one cycle later
// Notes: random writes mixed with boundary words
`timescale 1ns/100ps
`default_nettype none
module spc_link_config_tb_top;
    logic SYS_CLK, RST, WR_EN, RD_EN, RD_VALID, WR_ACK, WR_REFUSED, FRAME_VALID, FRAME_ACCEPT;
    logic [15:0] ADDR, WR_DATA, RD_DATA, st, bd, fm, a;
    logic [7:0] FRAME_ADDR, STATION_ADDR, fa;
    spc_pkg::spc_port_cfg_t RS232_CFG, RS485_CFG;
    int n_fail, cmp_count, seed, i;
    logic [31:0] cor [9] = '{32'h030000ff, 32'h03000000, 32'h03000001, 32'h03020055,
        32'h03020056, 32'h03040088, 32'h03040089, 32'h03060001, 32'h03040027};
    spc_link_config i_dut (.*);
    spc_host_model i_host (.sys_clk(SYS_CLK), .frame_valid(FRAME_VALID), .frame_addr(FRAME_ADDR));
    initial begin
        SYS_CLK = 1'b0;
        forever #10 SYS_CLK = ~SYS_CLK;
    end
    function automatic logic [20:0] ecfg(input logic [3:0] b, input logic [3:0] f);
        int r;
        r = (b == 4'h4) ? 57600 : (b == 4'h5) ? 115200 : 4800 << b;
        return {16'((spc_pkg::CLK_HZ + r / 2) / r), f > 4'h5, f > 4'h2, 2'(f % 3), f % 3 == 0};
    endfunction
    function automatic logic wok(input logic [15:0] ad, input logic [15:0] d);
        if (ad == spc_pkg::ADDR_STATION) return d >= 16'h0001 && d <= 16'h007f;
        if (ad == spc_pkg::ADDR_BAUD) return d[15:8] == 0 && d[7:4] <= 5 && d[3:0] <= 5;
        return ad == spc_pkg::ADDR_FORMAT && d[15:8] == 0 && d[7:4] <= 8 && d[3:0] <= 8;
    endfunction
    task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] ad, input logic [15:0] d);
        logic ok;
        ok = wok(ad, d);
        WR_EN = 1'b1;
        ADDR = ad;
        WR_DATA = d;
        @(negedge SYS_CLK);
        cmp("wr_ack", ok, WR_ACK);
        cmp("wr_refused", !ok, WR_REFUSED);
        WR_EN = 1'b0;
        if (ok && ad == spc_pkg::ADDR_STATION) st = d;
        if (ok && ad == spc_pkg::ADDR_BAUD) bd = d;
        if (ok && ad == spc_pkg::ADDR_FORMAT) fm = d;
        @(negedge SYS_CLK);
        cmp("rs232_cfg", ecfg(bd[3:0], fm[3:0]), RS232_CFG);
        cmp("rs485_cfg", ecfg(bd[7:4], fm[7:4]), RS485_CFG);
        cmp("station", st[7:0], STATION_ADDR);
        cmp("wr_pulse", 0, {WR_ACK, WR_REFUSED});
    endtask
    task automatic rd(input logic [15:0] ad);
        RD_EN = 1'b1;
        ADDR = ad;
        @(negedge SYS_CLK);
        cmp("rd_valid", 1, RD_VALID);
        cmp("rd_data", ad == 16'h0300 ? st : ad == 16'h0302 ? bd : ad == 16'h0304 ? fm : 0, RD_DATA);
        RD_EN = 1'b0;
        @(negedge SYS_CLK);
    endtask
    task automatic do_reset();
        RST = 1'b1;
        st = spc_pkg::RST_STATION;
        bd = spc_pkg::RST_BAUD;
        fm = spc_pkg::RST_FORMAT;
        repeat (4) @(negedge SYS_CLK);
        RST = 1'b0;
        for (int k = 0; k < 3; k++) rd(16'h0300 + 16'(2 * k));
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        n_fail++;
        end_of_test;
    end
    initial begin
        {WR_EN, RD_EN, ADDR, WR_DATA, n_fail, cmp_count} = '0;
        seed = 4007;
        do_reset();
        for (int k = 0; k < 9; k++) wr(spc_pkg::ADDR_FORMAT, {8'h00, 4'(8 - k), 4'(k)});
        for (int k = 0; k < 6; k++) wr(spc_pkg::ADDR_BAUD, {8'h00, 4'(5 - k), 4'(k)});
        for (i = 0; i < 80; i++) begin
            a = 16'h0300 + 16'(($random(seed) & 3) * 2);
            {a, WR_DATA} = (i < 9) ? cor[i] : {a, 16'($random(seed) & 16'h01ff)};
            wr(a, WR_DATA);
            rd(a);
            fa = ($random(seed) & 1) ? st[7:0] : (($random(seed) & 1) ? 8'hff : 8'($random(seed)));
            i_host.send(fa, 1 + ($random(seed) & 3));
            cmp("frame_accept", fa == 8'hff || fa == st[7:0], FRAME_ACCEPT);
        end
        do_reset();
        end_of_test;
    end
endmodule // spc_link_config_tb_top
`default_nettype wire
